/* File: bench/atm_cell_tx_slave_port_tb.sv */
// Bench: port off, one cell out, then deselect.
// Assumes the master model runs the link clock.
`timescale 1ns/1ns
`default_nettype none
module atm_cell_tx_slave_port_tb;
	logic core_clk = 1'h0, rst = 1'h1, strap = 1'h0, valid = 1'h0, want = 1'h1;
	logic lclk, fetch, sel, din_rdy, bus_oe, start, start_oe, rdy, rdy_oe;
	logic [4:0] want_addr = 5'h01, addr;
	logic [7:0] din = 8'h00, bus;
	int err_total, n_checks, cyc;
	atm_master_model atm_master_model_inst (.want, .want_addr, .lclk, .fetch, .addr);
	atm_cell_tx_slave_port atm_cell_tx_slave_port_inst (.core_clk, .rst, .tx_link_clock(lclk),
		.tx_fetch_request(fetch), .tx_slave_select_addr(addr), .port_select_strap(strap),
		.tx_byte_bus(bus), .tx_byte_bus_oe(bus_oe), .tx_cell_start(start),
		.tx_cell_start_oe(start_oe), .tx_cell_ready(rdy), .tx_cell_ready_oe(rdy_oe),
		.atm_port_select(sel), .cell_byte(din), .cell_byte_valid(valid), .cell_byte_ready(din_rdy));
	task chk(input logic [15:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %0t got %h", $time, got);
		end
	endtask
	task summarize;
		if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task fill;
		for (int i = 0; i < 53; i++) begin
			din <= 8'h10 + 8'(i);
			valid <= 1'h1;
			@(posedge core_clk);
		end
		valid <= 1'h0;
		repeat (9) @(posedge lclk);
	endtask
	task t_off;
		fill;
		chk({sel, bus_oe, start_oe, rdy_oe, start, rdy, bus}, 16'h0000);
	endtask
	task t_send;
		fill;
		chk({din_rdy, sel, rdy, rdy_oe}, 16'h0007);
		@(posedge core_clk) want <= 1'h1;
		for (int k = 0; k < 9 && start !== 1'h1; k++) @(posedge lclk);
		for (int k = 0; k < 53; k++) begin
			chk({start, bus_oe, bus}, {k == 0, 9'h110 + 9'(k)});
			@(posedge lclk);
		end
		repeat (2) @(posedge lclk);
		chk({din_rdy, rdy}, 16'h0002);
	endtask
	task t_desel;
		@(posedge core_clk) want_addr <= 5'h02;
		repeat (3) @(posedge lclk);
		chk({bus_oe, start_oe, rdy_oe}, 16'h0000);
	endtask
	initial forever #25 core_clk = ~core_clk;
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'h0;
		t_off;
		@(posedge core_clk) rst <= 1'h1;
		strap <= 1'h1;
		want <= 1'h0;
		repeat (6) @(posedge core_clk);
		rst <= 1'h0;
		t_send;
		t_desel;
		summarize;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			summarize;
		end
	end
endmodule // atm_cell_tx_slave_port_tb
bind atm_cell_tx_slave_port atm_tx_port_checker atm_tx_port_checker_inst (.core_clk, .rst,
	.tx_byte_bus, .tx_byte_bus_oe, .tx_cell_start, .tx_cell_start_oe, .tx_cell_ready,
	.atm_port_select);
`default_nettype wire

/* File: bench/atm_master_model.sv */
// Master controller model: free-running link clock, fetch and select.
// Assumes the bench sets want and want_addr; they launch on link rises.
`timescale 1ns/1ns
`default_nettype none
module atm_master_model (
	input  wire logic       want,
	input  wire logic [4:0] want_addr,
	output var  logic       lclk,
	output var  logic       fetch,
	output var  logic [4:0] addr
);
	initial {lclk, fetch, addr} = 7'h00;
	always #200 lclk = ~lclk;
	always @(posedge lclk) fetch <= want;
	always @(posedge lclk) addr <= want_addr;
endmodule // atm_master_model
`default_nettype wire

/* File: bench/atm_tx_port_checker.sv */
// Output checks for the ATM cell transmit slave port.
// Assumes it is bound to the port module and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module atm_tx_port_checker (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic [7:0] tx_byte_bus,
	input wire logic       tx_byte_bus_oe,
	input wire logic       tx_cell_start,
	input wire logic       tx_cell_start_oe,
	input wire logic       tx_cell_ready,
	input wire logic       atm_port_select
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_hold; tx_cell_start[*6]; endsequence
	property p_off; !atm_port_select |-> !tx_byte_bus_oe && !tx_cell_start_oe; endproperty
	a_off: assert property (p_off) else $error("off but driving");
	property p_zero; !atm_port_select |-> tx_byte_bus == 8'h00 && !tx_cell_start; endproperty
	a_zero: assert property (p_zero) else $error("off but active");
	property p_sel; tx_byte_bus_oe |-> atm_port_select; endproperty
	a_sel: assert property (p_sel) else $error("strap ignored");
	property p_first; $rose(tx_cell_start) |-> tx_byte_bus_oe && tx_cell_start_oe; endproperty
	a_first: assert property (p_first) else $error("start undriven");
	property p_hold; $rose(tx_cell_start) |-> s_hold; endproperty
	a_hold: assert property (p_hold) else $error("start short");
	property p_byte; $changed(tx_byte_bus) |=> $stable(tx_byte_bus)[*5]; endproperty
	a_byte: assert property (p_byte) else $error("byte short");
	property p_rdy; tx_cell_start |-> !tx_cell_ready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready with start");
	property p_pair; tx_cell_start_oe == tx_byte_bus_oe; endproperty
	a_pair: assert property (p_pair) else $error("enables differ");
endmodule // atm_tx_port_checker
`default_nettype wire

/* File: hdl/atm_cell_tx_slave_port.v */
// Transmit side of an ATM cell slave port toward a master controller.
// Assumes link pins arrive asynchronously and the link clock is far slower than core_clk.
//
// Function
// - Enable seen, first byte and start follow
// - Start strobe marks first byte on edge
// - Bytes sent one per rising link clock edge
// - Respond only when select address matches
// - Strap one selects port, zero serial
// - Disabled port ties off its pins
// - Cell ready high only for complete cell
`timescale 1ns/1ns
`default_nettype none
`include "atm_tx_defs.vh"
module atm_cell_tx_slave_port (
	input  wire                   core_clk,
	input  wire                   rst,
	input  wire                   tx_link_clock,
	input  wire                   tx_fetch_request,
	input  wire [`TX_ADDR_W-1:0]  tx_slave_select_addr,
	input  wire                   port_select_strap,
	output reg  [`TX_BYTE_W-1:0]  tx_byte_bus,
	output reg                    tx_byte_bus_oe,
	output reg                    tx_cell_start,
	output reg                    tx_cell_start_oe,
	output reg                    tx_cell_ready,
	output reg                    tx_cell_ready_oe,
	output reg                    atm_port_select,
	input  wire [`TX_BYTE_W-1:0]  cell_byte,
	input  wire                   cell_byte_valid,
	output wire                   cell_byte_ready
);
	localparam [1:0] ST_STRAP = 2'b00;
	localparam [1:0] ST_OFF   = 2'b01;
	localparam [1:0] ST_ON    = 2'b10;

	reg [`SYNC3_W-1:0]     clk_sync_ff;
	reg [`SYNC2_W-1:0]     fetch_sync_ff;
	reg                    fetch_hist_ff;
	reg [`SYNC2_W-1:0]     strap_sync_ff;
	reg [`TX_ADDR_W-1:0]   addr_meta_ff;
	reg [`TX_ADDR_W-1:0]   addr_sync_ff;
	reg [`TX_ADDR_W-1:0]   addr_hist_ff;

	reg [1:0]              state_ff;
	reg [1:0]              strap_cnt_ff;

	reg [1:0]              nxt_state;
	reg [1:0]              nxt_strap_cnt;
	reg                    nxt_port_select;
	reg [`TX_BYTE_W-1:0]   nxt_byte_bus;
	reg                    nxt_drive_oe;
	reg                    nxt_cell_start;
	reg                    nxt_cell_ready;

	wire                   link_rise;
	wire                   selected;
	wire                   fetch_seen;
	wire                   send_byte;
	wire [`TX_BYTE_W-1:0]  rd_byte;
	wire                   rd_first;
	wire                   cell_full;
	wire                   cell_avail;

	// Own-address decode for the select path.
	function is_own_addr;
		input [`TX_ADDR_W-1:0] sel_addr;
		begin
			is_own_addr = (sel_addr == `TX_OWN_ADDR);
		end
	endfunction

	function rose_between;
		input now_level;
		input old_level;
		begin
			rose_between = now_level & ~old_level;
		end
	endfunction

	tx_cell_store u_store (
		.core_clk   (core_clk),
		.rst        (rst),
		.wr_byte    (cell_byte),
		.wr_valid   (cell_byte_valid),
		.wr_ready   (cell_byte_ready),
		.rd_advance (send_byte),
		.rd_byte    (rd_byte),
		.rd_first   (rd_first),
		.cell_full  (cell_full),
		.cell_avail (cell_avail)
	);

	// Two flops on every pin input. The third stage holds the level from before the link edge,
	// so a fetch or address that the master changes just after its own edge counts one cycle later.
	always @(posedge core_clk) begin
		if (rst) begin
			clk_sync_ff   <= `SYNC3_ZERO;
			fetch_sync_ff <= `SYNC2_ZERO;
			fetch_hist_ff <= 1'b0;
			strap_sync_ff <= `SYNC2_ZERO;
			addr_meta_ff  <= `TX_ADDR_ZERO;
			addr_sync_ff  <= `TX_ADDR_ZERO;
			addr_hist_ff  <= `TX_ADDR_ZERO;
		end else begin
			clk_sync_ff   <= {clk_sync_ff[`SYNC_OUT:`SYNC_IN], tx_link_clock};
			fetch_sync_ff <= {fetch_sync_ff[`SYNC_IN], tx_fetch_request};
			fetch_hist_ff <= fetch_sync_ff[`SYNC_OUT];
			strap_sync_ff <= {strap_sync_ff[`SYNC_IN], port_select_strap};
			addr_meta_ff  <= tx_slave_select_addr;
			addr_sync_ff  <= addr_meta_ff;
			addr_hist_ff  <= addr_sync_ff;
		end
	end

	// All link timing is taken from the master's clock edges.
	assign link_rise  = rose_between(clk_sync_ff[`SYNC_OUT], clk_sync_ff[`SYNC_HIST]);
	assign fetch_seen = fetch_hist_ff;
	assign selected   = atm_port_select && is_own_addr(addr_hist_ff);
	assign send_byte  = link_rise && selected && fetch_seen && cell_full;

	// The strap is latched once after reset release so later pin noise cannot flip the mode.
	always @* begin
		nxt_state       = state_ff;
		nxt_strap_cnt   = strap_cnt_ff;
		nxt_port_select = atm_port_select;
		case (state_ff)
			ST_STRAP: begin
				if (strap_cnt_ff == `STRAP_WAIT) begin
					if (strap_sync_ff[`SYNC_OUT]) begin
						nxt_state       = ST_ON;
						nxt_port_select = 1'b1;
					end else begin
						nxt_state       = ST_OFF;
						nxt_port_select = 1'b0;
					end
				end else begin
					nxt_strap_cnt = strap_cnt_ff + `STRAP_CNT_ONE;
				end
			end
			ST_OFF: begin
				nxt_port_select = 1'b0;
			end
			ST_ON: begin
				nxt_port_select = 1'b1;
			end
			default: begin
				nxt_state       = ST_STRAP;
				nxt_strap_cnt   = `STRAP_CNT_ZERO;
				nxt_port_select = 1'b0;
			end
		endcase
	end

	always @(posedge core_clk) begin
		if (rst) begin
			state_ff        <= ST_STRAP;
			strap_cnt_ff    <= `STRAP_CNT_ZERO;
			atm_port_select <= 1'b0;
		end else begin
			state_ff        <= nxt_state;
			strap_cnt_ff    <= nxt_strap_cnt;
			atm_port_select <= nxt_port_select;
		end
	end

	// Tie-off keeps every output low with its enable off while the serial port owns the pins.
	always @* begin
		nxt_byte_bus   = tx_byte_bus;
		nxt_cell_start = tx_cell_start;
		if (!atm_port_select) begin
			nxt_byte_bus   = `TX_BYTE_ZERO;
			nxt_cell_start = 1'b0;
		end else if (link_rise) begin
			if (send_byte) begin
				nxt_byte_bus   = rd_byte;
				nxt_cell_start = rd_first;
			end else begin
				nxt_cell_start = 1'b0;
			end
		end
	end

	always @* begin
		nxt_drive_oe   = tx_byte_bus_oe;
		nxt_cell_ready = tx_cell_ready;
		if (!atm_port_select) begin
			nxt_drive_oe   = 1'b0;
			nxt_cell_ready = 1'b0;
		end else if (link_rise) begin
			nxt_drive_oe   = selected;
			// Ready drops with the first byte, since the cell is then no longer waiting.
			nxt_cell_ready = selected & cell_avail & ~send_byte;
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			tx_byte_bus   <= `TX_BYTE_ZERO;
			tx_cell_start <= 1'b0;
		end else begin
			tx_byte_bus   <= nxt_byte_bus;
			tx_cell_start <= nxt_cell_start;
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			tx_byte_bus_oe   <= 1'b0;
			tx_cell_start_oe <= 1'b0;
			tx_cell_ready    <= 1'b0;
			tx_cell_ready_oe <= 1'b0;
		end else begin
			tx_byte_bus_oe   <= nxt_drive_oe;
			tx_cell_start_oe <= nxt_drive_oe;
			tx_cell_ready    <= nxt_cell_ready;
			tx_cell_ready_oe <= nxt_drive_oe;
		end
	end
endmodule // atm_cell_tx_slave_port
`default_nettype wire

/* File: hdl/tx_cell_store.v */
// One-cell byte store between the user side and the transmit port.
// Assumes writer and reader share core_clk; the cell is sent only once complete.
`timescale 1ns/1ns
`default_nettype none
`include "atm_tx_defs.vh"
module tx_cell_store (
	input  wire                   core_clk,
	input  wire                   rst,
	input  wire [`TX_BYTE_W-1:0]  wr_byte,
	input  wire                   wr_valid,
	output wire                   wr_ready,
	input  wire                   rd_advance,
	output wire [`TX_BYTE_W-1:0]  rd_byte,
	output wire                   rd_first,
	output wire                   cell_full,
	output wire                   cell_avail
);
	reg [`TX_BYTE_W-1:0] mem [0:`TX_CELL_LEN-1];
	reg [`TX_IDX_W-1:0]  wr_idx_ff;
	reg [`TX_IDX_W-1:0]  rd_idx_ff;
	reg                  full_ff;
	reg                  ready_ff;
	reg                  nxt_full;
	wire                 wr_fire;
	wire                 rd_last;

	function idx_is_last;
		input [`TX_IDX_W-1:0] idx;
		begin
			idx_is_last = (idx == `TX_CELL_LEN - `TX_IDX_ONE);
		end
	endfunction

	// Writes stall while a cell waits or drains, so a partly sent cell is never overwritten.
	// Ready has a flop of its own so that the port's user-side output comes from a register.
	assign wr_ready   = ready_ff;
	assign wr_fire    = wr_valid & ~full_ff;
	assign rd_byte    = mem[rd_idx_ff];
	assign rd_first   = (rd_idx_ff == `TX_IDX_ZERO);
	assign cell_full  = full_ff;
	assign cell_avail = full_ff & rd_first;
	assign rd_last    = idx_is_last(rd_idx_ff);

	always @(posedge core_clk) begin
		if (wr_fire) begin
			mem[wr_idx_ff] <= wr_byte;
		end
	end

	always @* begin
		nxt_full = full_ff;
		if (wr_fire && idx_is_last(wr_idx_ff)) begin
			nxt_full = 1'b1;
		end
		if (rd_advance && full_ff && rd_last) begin
			nxt_full = 1'b0;
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			wr_idx_ff <= `TX_IDX_ZERO;
			rd_idx_ff <= `TX_IDX_ZERO;
			full_ff   <= 1'b0;
			ready_ff  <= 1'b1;
		end else begin
			full_ff  <= nxt_full;
			ready_ff <= ~nxt_full;
			if (wr_fire) begin
				if (idx_is_last(wr_idx_ff)) begin
					wr_idx_ff <= `TX_IDX_ZERO;
				end else begin
					wr_idx_ff <= wr_idx_ff + `TX_IDX_ONE;
				end
			end
			if (rd_advance && full_ff) begin
				if (rd_last) begin
					rd_idx_ff <= `TX_IDX_ZERO;
				end else begin
					rd_idx_ff <= rd_idx_ff + `TX_IDX_ONE;
				end
			end
		end
	end
endmodule // tx_cell_store
`default_nettype wire

/* File: shared/atm_tx_defs.vh */
// Constants for the ATM cell transmit slave port.
// Assumes inclusion by bare name from the design files.
`ifndef ATM_TX_DEFS_VH
`define ATM_TX_DEFS_VH
`define TX_BYTE_W      8
`define TX_ADDR_W      5
`define TX_CELL_LEN    6'd53
`define TX_IDX_W       6
`define TX_IDX_ZERO    6'h00
`define TX_IDX_ONE     6'h01
`define TX_BYTE_ZERO   8'h00
`define TX_ADDR_ZERO   5'h00
`define TX_OWN_ADDR    5'h01
`define STRAP_WAIT     2'h3
`define STRAP_CNT_ZERO 2'h0
`define STRAP_CNT_ONE  2'h1
`define SYNC2_W        2
`define SYNC3_W        3
`define SYNC2_ZERO     2'h0
`define SYNC3_ZERO     3'h0
`define SYNC_IN        0
`define SYNC_OUT       1
`define SYNC_HIST      2
`endif
